// *** include/pwr_fail_map.svh ***
/*
  Constants for the power-fail lock-out control: tick rate, debounce and grace windows.
  Assumes a single 50 MHz system clock.
*/
`ifndef PWR_FAIL_MAP_SVH
`define PWR_FAIL_MAP_SVH
// ==========================================================================
// Timing and reset values
// ==========================================================================
`define CLK_PERIOD_NS      20
`define TICK_US            32
`define TICK_CYCLES        ((`TICK_US * 1000) / `CLK_PERIOD_NS)
`define DEBOUNCE_MIN_US    30
`define DEBOUNCE_TICKS     2
`define GRACE_US           480
`define GRACE_TICKS        (`GRACE_US / `TICK_US)
`define HOLD_LIMIT_US      30
`define HOLD_LIMIT_CYCLES  ((`HOLD_LIMIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_FAIL_RESET     1'h1
`endif

// *** include/pwr_fail_pkg.sv ***
/*
  Types for the power-fail lock-out control.
  Assumes the map header is compiled alongside.
*/
package pwr_fail_pkg;
  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_POWER_OK,
    ST_FAILED,
    ST_GRACE,
    ST_LOCKED
  } lock_state_t;

  typedef struct packed {
    lock_state_t state;
    logic [10:0] tick_cnt;
    logic        tick;
    logic [4:0]  deb_cnt;
    logic [4:0]  grace_cnt;
    logic [10:0] hold_cnt;
    logic        power_failed;
    logic        locked;
    logic        standby;
    logic        osc_fail;
    logic        time_save_en;
    logic        low_batt;
    logic        irq;
    logic        multi_function_output;
    logic        copy;
    logic        timers_halted;
    logic        irqs_halted;
    logic [10:0] hold_run;
    logic [11:0] low_run;
    logic [11:0] high_run;
  } pf_state_t;
endpackage : pwr_fail_pkg

// *** rtl/power_fail_lockout_control.sv ***
/*
  Power-failure supervision: debounce, interrupt, bus lock-out, standby isolation, status bits.
  Assumes all inputs synchronous to mclk_in; analog comparators deliver digital levels.
*/
`timescale 1ns/10ps
`include "pwr_fail_map.svh"

module power_fail_lockout_control #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic mclk_in,
  input  wire logic reset_in,
  input  wire logic power_loss_n_in,
  input  wire logic battery_switch_in,
  input  wire logic battery_low_in,
  input  wire logic chip_sel_n_in,
  input  wire logic read_n_in,
  input  wire logic write_n_in,
  input  wire logic delay_en_in,
  input  wire logic pf_irq_en_in,
  input  wire logic pf_route_mfo_in,
  input  wire logic timer_pf_op_in,
  input  wire logic irq_pf_op_in,
  input  wire logic clock_start_in,
  input  wire logic tse_set_in,
  input  wire logic tse_clear_in,
  output logic      power_fail_flag_out,
  output logic      bus_locked_out,
  output logic      timer_inputs_locked_out,
  output logic      outputs_open_drain_out,
  output logic      pf_irq_output_out,
  output logic      pf_multi_function_output_out,
  output logic      timers_halted_out,
  output logic      irqs_halted_out,
  output logic      osc_fail_flag_out,
  output logic      low_battery_out,
  output logic      time_save_en_out,
  output logic      time_save_copy_out
);
  pwr_fail_pkg::pf_state_t s_r;
  pwr_fail_pkg::pf_state_t s_nxt;
  logic                    strobe;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  // A steady level is accepted on the tick that completes the debounce count.
  function automatic logic deb_done(input logic [4:0] cnt);
    deb_done = (cnt == 5'(`DEBOUNCE_TICKS - 1));
  endfunction : deb_done

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_nxt  = s_r;
    strobe = !chip_sel_n_in && (!read_n_in || !write_n_in);
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == 11'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = 11'h000;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 11'h001;
    end
    case (s_r.state)
      pwr_fail_pkg::ST_POWER_OK: begin
        if (power_loss_n_in) begin
          s_nxt.deb_cnt = 5'h00;
        end else if (s_r.tick) begin
          s_nxt.deb_cnt = s_r.deb_cnt + 5'h01;
          if (deb_done(s_r.deb_cnt)) begin
            s_nxt.power_failed = 1'b1;
            s_nxt.deb_cnt      = 5'h00;
            s_nxt.grace_cnt    = 5'h00;
            s_nxt.hold_cnt     = 11'h000;
            s_nxt.state        = delay_en_in ? pwr_fail_pkg::ST_GRACE : pwr_fail_pkg::ST_FAILED;
          end
        end
      end
      pwr_fail_pkg::ST_FAILED: begin
        // hold off while an access is in progress
        if (!strobe || s_r.hold_cnt == 11'(`HOLD_LIMIT_CYCLES)) begin
          s_nxt.state = pwr_fail_pkg::ST_LOCKED;
        end else begin
          s_nxt.hold_cnt = s_r.hold_cnt + 11'h001;
        end
      end
      pwr_fail_pkg::ST_GRACE: begin
        // early lock-out on delay enable clear
        if (!delay_en_in || (s_r.tick && s_r.grace_cnt == 5'(`GRACE_TICKS - 1))) begin
          s_nxt.state    = pwr_fail_pkg::ST_FAILED;
          s_nxt.hold_cnt = 11'h000;
        end else if (s_r.tick) begin
          s_nxt.grace_cnt = s_r.grace_cnt + 5'h01;
        end
      end
      pwr_fail_pkg::ST_LOCKED: begin
        if (!power_loss_n_in) begin
          s_nxt.deb_cnt = 5'h00;
        end else if (s_r.tick) begin
          s_nxt.deb_cnt = s_r.deb_cnt + 5'h01;
          if (deb_done(s_r.deb_cnt)) begin
            s_nxt.deb_cnt      = 5'h00;
            s_nxt.power_failed = 1'b0;
            s_nxt.state        = pwr_fail_pkg::ST_POWER_OK;
          end
        end
      end
      default: begin
        s_nxt.state = pwr_fail_pkg::ST_POWER_OK;
      end
    endcase
    // lock-out state drives the bus isolation
    s_nxt.locked  = (s_nxt.state == pwr_fail_pkg::ST_LOCKED);
    s_nxt.standby = battery_switch_in;
    // interrupt on failure, gated by enable
    s_nxt.irq = s_nxt.power_failed && pf_irq_en_in && !pf_route_mfo_in;
    s_nxt.multi_function_output = s_nxt.power_failed && pf_irq_en_in && pf_route_mfo_in;
    // oscillator fail cleared only by clock start
    // no other path but reset touches the flag
    if (clock_start_in) begin
      s_nxt.osc_fail = 1'b0;
    end
    // low battery only on main supply with enable
    s_nxt.low_batt = battery_low_in && !battery_switch_in && pf_irq_en_in;
    // switchover clear wins over a set
    if (battery_switch_in && !s_r.standby) begin
      s_nxt.time_save_en = 1'b0;
    end else if (tse_set_in) begin
      s_nxt.time_save_en = 1'b1;
    end else if (tse_clear_in) begin
      s_nxt.time_save_en = 1'b0;
    end
    s_nxt.copy = s_nxt.time_save_en;
    s_nxt.timers_halted = s_nxt.power_failed && !timer_pf_op_in;
    s_nxt.irqs_halted   = s_nxt.power_failed && !irq_pf_op_in;
    // Run lengths feed only the checks; twelve bits cover two ticks while the tick stays under 2048 clocks.
    // held access length
    if (s_r.state == pwr_fail_pkg::ST_FAILED && strobe) begin
      s_nxt.hold_run = s_r.hold_run + 11'h001;
    end else begin
      s_nxt.hold_run = 11'h000;
    end
    if (power_loss_n_in) begin
      s_nxt.low_run = 12'h000;
    end else if (s_r.low_run != 12'hFFF) begin
      s_nxt.low_run = s_r.low_run + 12'h001;
    end
    if (!power_loss_n_in) begin
      s_nxt.high_run = 12'h000;
    end else if (s_r.high_run != 12'hFFF) begin
      s_nxt.high_run = s_r.high_run + 12'h001;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s_r          <= '0;
      s_r.state    <= pwr_fail_pkg::ST_POWER_OK;
      s_r.osc_fail <= `OSC_FAIL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // status mirrors failed signal
  assign power_fail_flag_out          = s_r.power_failed;
  assign bus_locked_out               = s_r.locked;
  assign timer_inputs_locked_out      = s_r.standby;
  assign outputs_open_drain_out       = s_r.standby;
  assign pf_irq_output_out            = s_r.irq;
  assign pf_multi_function_output_out = s_r.multi_function_output;
  // halt decisions; a set bit halts the function, a set operation bit keeps it running
  assign timers_halted_out            = s_r.timers_halted;
  assign irqs_halted_out              = s_r.irqs_halted;
  assign osc_fail_flag_out            = s_r.osc_fail;
  assign low_battery_out              = s_r.low_batt;
  assign time_save_en_out             = s_r.time_save_en;
  assign time_save_copy_out           = s_r.copy;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // masked interrupt
  a_irq_gated: assert property (@(posedge mclk_in) disable iff (reset_in)
    !pf_irq_en_in |=> !pf_irq_output_out && !pf_multi_function_output_out)
    else $error("Power fail interrupt issued while disabled.");
  a_irq_route: assert property (@(posedge mclk_in) disable iff (reset_in)
    pf_irq_output_out |-> !pf_multi_function_output_out)
    else $error("Interrupt on both outputs.");
  a_early_lock: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_r.state == pwr_fail_pkg::ST_GRACE && !delay_en_in && !strobe) |=> ##1 bus_locked_out)
    else $error("No lock-out after delay enable cleared.");
  a_hold_force: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_r.hold_run <= 11'(`HOLD_LIMIT_CYCLES + 1)))
    else $error("Long strobe did not force lock-out.");
  a_lock_needs_fail: assert property (@(posedge mclk_in) disable iff (reset_in)
    bus_locked_out |-> power_fail_flag_out)
    else $error("Locked without power failed.");
  a_osc_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
    $fell(osc_fail_flag_out) |-> $past(clock_start_in))
    else $error("Oscillator fail cleared without clock start.");
  a_lowbatt_main: assert property (@(posedge mclk_in) disable iff (reset_in)
    low_battery_out |-> $past(!battery_switch_in && pf_irq_en_in))
    else $error("Low battery set out of context.");
  a_tse_switch: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(battery_switch_in) |=> !time_save_en_out)
    else $error("Time save enable not cleared on switchover.");
  a_fail_debounce: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(power_fail_flag_out) |-> $past(!power_loss_n_in))
    else $error("Failure flagged with input high.");
  a_fail_min: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(power_fail_flag_out) |-> s_r.low_run > 12'(TICK_CYCLES))
    else $error("Failure flagged before the debounce minimum.");
  a_fail_max: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_r.low_run == 12'(2 * TICK_CYCLES)) |-> power_fail_flag_out)
    else $error("Failure not flagged within the debounce maximum.");
  a_prompt_lock: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_r.state == pwr_fail_pkg::ST_FAILED && !strobe) |=> bus_locked_out)
    else $error("No lock-out once the access ended.");
  a_grace_open: assert property (@(posedge mclk_in) disable iff (reset_in)
    (s_r.state == pwr_fail_pkg::ST_GRACE) |-> !bus_locked_out)
    else $error("Bus locked during the grace window.");
  a_unlock_min: assert property (@(posedge mclk_in) disable iff (reset_in)
    $fell(bus_locked_out) |-> s_r.high_run > 12'(TICK_CYCLES))
    else $error("Unlocked before the debounce minimum.");
  a_flag_clear: assert property (@(posedge mclk_in) disable iff (reset_in)
    $fell(power_fail_flag_out) |-> $past(power_loss_n_in))
    else $error("Failure flag cleared with input low.");
  a_irq_follow: assert property (@(posedge mclk_in) disable iff (reset_in)
    (pf_irq_output_out || pf_multi_function_output_out) |-> power_fail_flag_out)
    else $error("Interrupt without power failure.");
  a_irq_raise: assert property (@(posedge mclk_in) disable iff (reset_in)
    (power_fail_flag_out && $past(pf_irq_en_in)) |->
    ({pf_irq_output_out, pf_multi_function_output_out} == {!$past(pf_route_mfo_in), $past(pf_route_mfo_in)}))
    else $error("Enabled interrupt missing on its routed output.");
  a_halt_timer: assert property (@(posedge mclk_in) disable iff (reset_in)
    timers_halted_out == (power_fail_flag_out && !$past(timer_pf_op_in)))
    else $error("Timer halt does not follow its operation bit.");
  a_halt_irq: assert property (@(posedge mclk_in) disable iff (reset_in)
    irqs_halted_out == (power_fail_flag_out && !$past(irq_pf_op_in)))
    else $error("Interrupt halt does not follow its operation bit.");
  a_standby_iso: assert property (@(posedge mclk_in) disable iff (reset_in)
    (timer_inputs_locked_out == $past(battery_switch_in)) && (outputs_open_drain_out == $past(battery_switch_in)))
    else $error("Standby isolation does not follow switchover.");
  a_tse_set: assert property (@(posedge mclk_in) disable iff (reset_in)
    ($past(tse_set_in) && !$past(battery_switch_in && !timer_inputs_locked_out)) |->
    (time_save_en_out && time_save_copy_out))
    else $error("Time save not enabled after a set.");
endmodule : power_fail_lockout_control

// *** verif/host_bus_model.sv ***
/*
  Host model: a processor that opens read or write cycles and owns the delay enable bit.
  Assumes the bench commands it between clock edges; it changes its lines at falling edges.
*/
`timescale 1ns/10ps
module host_bus_model (
  input  wire logic mclk_in,
  input  wire logic access_in,
  input  wire logic write_in,
  input  wire logic grace_in,
  output logic      chip_sel_n_out,
  output logic      read_n_out,
  output logic      write_n_out,
  output logic      delay_en_out
);
  // ====================
  // Bus cycle
  // ====================
  logic access_q = 1'h0;
  logic write_q  = 1'h0;
  logic grace_q  = 1'h1;
  // Strobes rest high, so no line floats before the first edge.
  initial {chip_sel_n_out, read_n_out, write_n_out, delay_en_out} = 4'hE;
  // Commands are taken on the rising edge, after the bench settled them, so the model never races the bench.
  always @(posedge mclk_in) begin
    {access_q, write_q, grace_q} <= {access_in, write_in, grace_in};
  end
  // An access stays open for as long as it is commanded, however long that is.
  always @(negedge mclk_in) begin
    chip_sel_n_out <= ~access_q;
    read_n_out     <= ~(access_q & ~write_q);
    write_n_out    <= ~(access_q & write_q);
  end
  always @(negedge mclk_in) begin
    delay_en_out <= grace_q;
  end
endmodule : host_bus_model

// *** verif/power_fail_lockout_control_tb_top.sv ***
/*
  Self-checking bench for the power-fail lock-out control.
  Assumes the host model and the design are compiled first; tick shortened to 4 clocks.
*/
`timescale 1ns/10ps
module power_fail_lockout_control_tb_top;
  logic clk = 1'h0, rst = 1'h1, pl_n = 1'h1, bsw = 1'h0, blow = 1'h0, en = 1'h0, rt = 1'h0;
  logic top = 1'h0, iop = 1'h0, cst = 1'h0, tset = 1'h0, tclr = 1'h0, acc = 1'h0, wr = 1'h0, gr = 1'h1;
  logic cs_n, rd_n, wr_n, dly;
  wire [11:0] o;
  int bad_count = 0;
  int checks = 0;
  localparam int FL = 0, LK = 1, IH = 2, TH = 3, MF = 4, IR = 5, OD = 6, TL = 7, CP = 8, TS = 9, LB = 10, OF = 11;
  always #10 clk = ~clk;
  // ====================
  // Design and host
  // ====================
  power_fail_lockout_control #(.TICK_CYCLES(4)) uut (.mclk_in(clk), .reset_in(rst), .power_loss_n_in(pl_n),
    .battery_switch_in(bsw), .battery_low_in(blow), .chip_sel_n_in(cs_n), .read_n_in(rd_n), .write_n_in(wr_n),
    .delay_en_in(dly), .pf_irq_en_in(en), .pf_route_mfo_in(rt), .timer_pf_op_in(top), .irq_pf_op_in(iop),
    .clock_start_in(cst), .tse_set_in(tset), .tse_clear_in(tclr), .power_fail_flag_out(o[FL]),
    .bus_locked_out(o[LK]), .timer_inputs_locked_out(o[TL]), .outputs_open_drain_out(o[OD]),
    .pf_irq_output_out(o[IR]), .pf_multi_function_output_out(o[MF]), .timers_halted_out(o[TH]),
    .irqs_halted_out(o[IH]), .osc_fail_flag_out(o[OF]), .low_battery_out(o[LB]),
    .time_save_en_out(o[TS]), .time_save_copy_out(o[CP]));
  host_bus_model host (.mclk_in(clk), .access_in(acc), .write_in(wr), .grace_in(gr),
    .chip_sel_n_out(cs_n), .read_n_out(rd_n), .write_n_out(wr_n), .delay_en_out(dly));
  // ====================
  // Helpers
  // ====================
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Waits at most n cycles for output i to reach v; n of zero checks at once.
  task automatic see(input int i, input logic v, input int n, input string m);
    int k;
    k = 0;
    while (o[i] !== v && k < n) begin
      @(negedge clk);
      k++;
    end
    checks++;
    if (o[i] !== v) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : see
  task automatic give_verdict;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic restore;
    pl_n = 1'h1;
    cyc(3);
    see(LK, 1'h1, 0, "early unlock");
    see(LK, 1'h0, 16, "no unlock");
    see(FL, 1'h0, 3, "flag stuck");
  endtask : restore
  // ====================
  // Scenarios
  // ====================
  task automatic t_osc;
    see(OF, 1'h1, 0, "osc flag clear");
    cyc(6);
    see(OF, 1'h1, 0, "osc flag lost");
    cst = 1'h1;
    see(OF, 1'h0, 3, "osc flag kept");
    $display("test osc done");
  endtask : t_osc
  task automatic t_prompt;
    gr = 1'h0;
    en = 1'h1;
    for (int r = 0; r < 2; r++) begin
      {rt, top, iop} = {3{r[0]}};
      pl_n = 1'h0;
      cyc(3);
      see(FL, 1'h0, 0, "flag early");
      see(FL, 1'h1, 12, "flag late");
      see(r ? MF : IR, 1'h1, 2, "no irq");
      see(r ? IR : MF, 1'h0, 0, "irq wrong pin");
      see(TH, ~top, 1, "timer halt");
      see(IH, ~iop, 0, "irq halt");
      see(LK, 1'h1, 3, "no prompt lock");
      restore();
    end
    $display("test prompt done");
  endtask : t_prompt
  task automatic t_quiet;
    en = 1'h0;
    blow = 1'h1;
    cyc(3);
    see(LB, 1'h0, 0, "low batt while off");
    pl_n = 1'h0;
    see(LK, 1'h1, 16, "no lock");
    see(MF, 1'h0, 0, "irq issued");
    restore();
    en = 1'h1;
    see(LB, 1'h1, 3, "low batt missed");
    $display("test quiet done");
  endtask : t_quiet
  task automatic t_grace;
    gr = 1'h1;
    for (int r = 0; r < 2; r++) begin
      pl_n = 1'h0;
      see(FL, 1'h1, 12, "flag late");
      cyc(r ? 20 : 54);
      see(LK, 1'h0, 0, "grace cut");
      gr = ~r[0];
      see(LK, 1'h1, r ? 4 : 12, "no lock");
      restore();
    end
    $display("test grace done");
  endtask : t_grace
  task automatic t_hold;
    for (int r = 0; r < 2; r++) begin
      {acc, wr} = {1'h1, r[0]};
      cyc(2);
      pl_n = 1'h0;
      see(FL, 1'h1, 12, "flag late");
      cyc(1400);
      see(LK, 1'h0, 0, "access cut");
      acc = r[0] ? 1'h0 : 1'h1;
      see(LK, 1'h1, r ? 4 : 200, "no lock");
      acc = 1'h0;
      restore();
    end
    $display("test hold done");
  endtask : t_hold
  task automatic t_standby;
    tset = 1'h1;
    cyc(1);
    tset = 1'h0;
    see(TS, 1'h1, 2, "tse not set");
    see(CP, 1'h1, 2, "no copy");
    pl_n = 1'h0;
    see(LK, 1'h1, 16, "no lock");
    see(TS, 1'h1, 0, "tse cleared early");
    see(TL, 1'h0, 0, "timer inputs early");
    bsw = 1'h1;
    see(TL, 1'h1, 2, "timer inputs open");
    see(OD, 1'h1, 0, "outputs driven");
    see(TS, 1'h0, 2, "tse kept");
    see(LB, 1'h0, 2, "low batt on battery");
    bsw = 1'h0;
    see(OD, 1'h0, 2, "still open drain");
    restore();
    tset = 1'h1;
    cyc(1);
    {tset, tclr} = 2'h1;
    cyc(1);
    tclr = 1'h0;
    see(TS, 1'h0, 2, "software clear");
    $display("test standby done");
  endtask : t_standby
  // ====================
  // Run
  // ====================
  initial begin
    cyc(8);
    rst = 1'h0;
    cyc(1);
    t_osc();
    t_prompt();
    t_quiet();
    t_grace();
    t_hold();
    t_standby();
    give_verdict();
  end
  // The longest test holds an access for some 1,500 cycles; this allows ample margin.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("BAD %0t watchdog", $time);
    give_verdict();
  end
endmodule : power_fail_lockout_control_tb_top
